// [hdl/icache_pkg.sv]
package icache_pkg;

  // fetch address layout
  localparam int ADDR_W      = 24;
  localparam int TAG_HI      = 23;
  localparam int TAG_LO      = 13;
  localparam int TAG_W       = TAG_HI - TAG_LO + 1;
  localparam int SET_HI      = 12;
  localparam int SET_LO      = 4;
  localparam int SET_W       = SET_HI - SET_LO + 1;
  localparam int NUM_SETS    = 512;
  localparam int WORD_HI     = 3;
  localparam int WORD_LO     = 2;
  localparam int WORDS       = 4;
  localparam int DATA_W      = 32;

  // status word bit positions
  localparam int FLUSH_BIT   = 13;
  localparam int ENABLE_BIT  = 14;
  localparam int FREEZE_BIT  = 15;

  // control register offsets (word index) and reset values
  localparam logic [1:0]  STATUS_OFS     = 2'h0;
  localparam logic [1:0]  GLOBAL_OFS     = 2'h1;
  localparam logic [15:0] GLOBAL_INIT    = 16'hce3c;
  localparam logic [15:0] GLOBAL_RST     = 16'h0000;
  localparam logic [2:0]  CTRL_RST       = 3'h0;

  typedef logic [TAG_W-1:0] tag_t;
  typedef logic [SET_W-1:0] set_t;
  typedef logic [1:0]       word_t;

  // fetch request from the processor
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } fetch_req_s;

  // request to the external memory unit
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              line;
  } mem_req_s;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FILL   = 2'b01,
    ST_DIRECT = 2'b11,
    ST_FLUSH  = 2'b10
  } cache_state_e;

endpackage : icache_pkg

// [hdl/cache_way.sv]
`timescale 1ns/1ps
// one way: tags, valid bits and data words
module cache_way
  import icache_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // lookup
  input  wire set_t              rd_set_i,
  input  wire word_t             rd_word_i,
  output logic                   valid_o,
  output tag_t                   tag_o,
  output logic [DATA_W-1:0]      data_o,
  // updates
  input  wire logic              wr_data_i,
  input  wire set_t              wr_set_i,
  input  wire word_t             wr_word_i,
  input  wire logic [DATA_W-1:0] wr_value_i,
  input  wire logic              wr_tag_i,
  input  wire tag_t              wr_tag_val_i,
  input  wire logic              inval_i,
  input  wire set_t              inval_set_i
);

  logic [DATA_W-1:0] data_mem [NUM_SETS*WORDS];
  tag_t              tag_mem  [NUM_SETS];
  logic [NUM_SETS-1:0] valid;
  logic [NUM_SETS-1:0] next_valid;

  // set-indexed lookup is combinational, so a hit answers next edge
  assign valid_o = valid[rd_set_i];
  assign tag_o   = tag_mem[rd_set_i];
  assign data_o  = data_mem[{rd_set_i, rd_word_i}];

  // valid bit updates: setting a line wins over invalidating the same set
  always_comb begin
    next_valid = valid;
    if (inval_i)
      next_valid[inval_set_i] = 1'b0;
    if (wr_tag_i)
      next_valid[wr_set_i] = 1'b1;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      valid <= '0;
    else
      valid <= next_valid;
  end

  // arrays carry no reset; contents are meaningless until valid is set
  always_ff @(posedge mclk_i) begin
    if (wr_data_i)
      data_mem[{wr_set_i, wr_word_i}] <= wr_value_i;
    if (wr_tag_i)
      tag_mem[wr_set_i] <= wr_tag_val_i;
  end

endmodule : cache_way

// [hdl/ctrl_bits.sv]
`timescale 1ns/1ps
// enable, flush and freeze bits plus the global control word
module ctrl_bits
  import icache_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [15:0]      reg_rdata_o,
  // to the cache core
  input  wire logic        flush_done_i,
  output logic             enable_o,
  output logic             flush_o,
  output logic             freeze_o
);

  logic        enable, flush, freeze;
  logic        next_enable, next_flush, next_freeze;
  logic [15:0] global_ctl, next_global_ctl;
  logic [15:0] rdata, next_rdata;

  assign enable_o    = enable;
  assign flush_o     = flush;
  assign freeze_o    = freeze;
  assign reg_rdata_o = rdata;

  // writes and the flush self-clear; a new flush request beats completion
  always_comb begin
    next_enable     = enable;
    next_flush      = flush;
    next_freeze     = freeze;
    next_global_ctl = global_ctl;
    next_rdata      = 16'h0000;
    if (flush_done_i)
      next_flush = 1'b0;
    if (reg_write_i && reg_addr_i == STATUS_OFS) begin
      next_enable = reg_wdata_i[ENABLE_BIT];
      next_freeze = reg_wdata_i[FREEZE_BIT];
      if (reg_wdata_i[FLUSH_BIT])
        next_flush = 1'b1;
    end
    // software only writes this while disabled; the hardware does not police it
    if (reg_write_i && reg_addr_i == GLOBAL_OFS)
      next_global_ctl = reg_wdata_i;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        STATUS_OFS: begin
          next_rdata[ENABLE_BIT] = enable;
          next_rdata[FLUSH_BIT]  = flush;
          next_rdata[FREEZE_BIT] = freeze;
        end
        GLOBAL_OFS: next_rdata = global_ctl;
        default:    next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {freeze, enable, flush} <= CTRL_RST;
      global_ctl <= GLOBAL_RST;
      rdata      <= 16'h0000;
    end else begin
      enable     <= next_enable;
      flush      <= next_flush;
      freeze     <= next_freeze;
      global_ctl <= next_global_ctl;
      rdata      <= next_rdata;
    end
  end

  reset_clear_a: assert property (@(posedge mclk_i) $fell(rst_i) |->
    !enable && !flush && !freeze) else $error("control bits not cleared by reset");
  flush_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    reg_write_i && reg_addr_i == STATUS_OFS && reg_wdata_i[FLUSH_BIT] |=> flush)
    else $error("flush request lost");

endmodule : ctrl_bits

// [hdl/icache_top.sv]
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Contract
// - address bits 23-13 are the tag stored on a fill
// - bits 12-4 choose one of 512 two-way sets
// - bits 3-2 choose the word within the line
// - byte bits 1-0 are ignored
// - hit needs matching tag and set valid bit
// - hit answers from the array with no external access
// - miss fetches the aligned four-word block, written word by word
// - requested word forwarded as soon as it is written
// - tag and valid written only after all four words
// - disabled cache passes every fetch straight to external memory
// - reset clears enable, flush and freeze
// - writing flush clears all valid bits, reads 1 until done
// - frozen cache serves hits but misses do not update arrays
// - frozen misses still fetch all four words
// - victim is the least recently used way, one toggling bit per set
// - fetch address is 24 bits
// - no snooping; stale lines stay until flushed
module icache_top
  import icache_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [1:0]        reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic [15:0]            reg_rdata_o,
  // processor fetch port
  input  wire logic              fetch_valid_i,
  input  wire fetch_req_s        fetch_req_i,
  output logic                   fetch_ready_o,
  output logic                   fetch_ack_o,
  output logic [DATA_W-1:0]      fetch_data_o,
  // external memory unit
  output logic                   mem_valid_o,
  output mem_req_s               mem_req_o,
  input  wire logic              mem_ready_i,
  input  wire logic              mem_rvalid_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i
);

  logic enable, flush, freeze, flush_done;

  ctrl_bits u_ctrl_bits (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_write_i  (reg_write_i),
    .reg_read_i   (reg_read_i),
    .reg_rdata_o  (reg_rdata_o),
    .flush_done_i (flush_done),
    .enable_o     (enable),
    .flush_o      (flush),
    .freeze_o     (freeze)
  );

  // address split; bits 1-0 are never looked at
  tag_t  req_tag;
  set_t  req_set;
  word_t req_word;
  assign req_tag  = fetch_req_i.addr[TAG_HI:TAG_LO];
  assign req_set  = fetch_req_i.addr[SET_HI:SET_LO];
  assign req_word = fetch_req_i.addr[WORD_HI:WORD_LO];

  cache_state_e state, next_state;
  tag_t         f_tag, next_f_tag;
  set_t         f_set, next_f_set;
  word_t        f_word, next_f_word;
  word_t        f_cnt, next_f_cnt;
  logic         f_way, next_f_way;
  logic         f_store, next_f_store;
  logic         f_issued, next_f_issued;
  logic         ack, next_ack;
  logic [DATA_W-1:0] rdata, next_rdata;
  set_t         fl_idx, next_fl_idx;
  logic [NUM_SETS-1:0] lru, next_lru;

  // per-way lookup signals
  logic [1:0]        w_valid, w_hit, w_wr_data, w_wr_tag;
  tag_t              w_tag  [2];
  logic [DATA_W-1:0] w_data [2];
  logic              any_hit, hit_way, inval;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_way
      cache_way u_cache_way (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .rd_set_i     (req_set),
        .rd_word_i    (req_word),
        .valid_o      (w_valid[g]),
        .tag_o        (w_tag[g]),
        .data_o       (w_data[g]),
        .wr_data_i    (w_wr_data[g]),
        .wr_set_i     (f_set),
        .wr_word_i    (f_cnt),
        .wr_value_i   (mem_rdata_i),
        .wr_tag_i     (w_wr_tag[g]),
        .wr_tag_val_i (f_tag),
        .inval_i      (inval),
        .inval_set_i  (fl_idx)
      );
      assign w_hit[g] = w_valid[g] && (w_tag[g] == req_tag);
    end
  endgenerate

  assign any_hit = |w_hit;
  assign hit_way = w_hit[1];
  assign inval   = (state == ST_FLUSH);

  logic last_word;
  assign last_word  = (state == ST_FILL) && mem_rvalid_i && f_cnt == 2'h3;
  assign flush_done = inval && fl_idx == set_t'(NUM_SETS - 1);

  // no processor write path reaches the arrays: lines change only by fills
  // and flushes, so software must flush after patching program memory
  // arrays only take words of a storing fill; frozen fills write nothing
  always_comb begin
    for (int w = 0; w < 2; w++) begin
      w_wr_data[w] = (state == ST_FILL) && mem_rvalid_i && f_store
                     && (f_way == w[0]);
      w_wr_tag[w]  = last_word && f_store && (f_way == w[0]);
    end
  end

  // requests wait while busy; a lookup is only done in idle
  assign fetch_ready_o   = (state == ST_IDLE) && !flush;
  assign fetch_ack_o     = ack;
  assign fetch_data_o    = rdata;
  assign mem_valid_o     = ((state == ST_FILL) || (state == ST_DIRECT)) && !f_issued;
  assign mem_req_o.addr  = (state == ST_FILL) ?
                           {f_tag, f_set, 4'h0} : {f_tag, f_set, f_word, 2'h0};
  assign mem_req_o.line  = (state == ST_FILL);

  // main control: lookup, fill, pass-through and flush sweep
  always_comb begin
    next_state    = state;
    next_f_tag    = f_tag;
    next_f_set    = f_set;
    next_f_word   = f_word;
    next_f_cnt    = f_cnt;
    next_f_way    = f_way;
    next_f_store  = f_store;
    next_f_issued = f_issued;
    next_ack      = 1'b0;
    next_rdata    = rdata;
    next_fl_idx   = fl_idx;
    next_lru      = lru;
    unique case (state)
      ST_IDLE: begin
        if (flush) begin
          next_state  = ST_FLUSH;
          next_fl_idx = '0;
        end else if (fetch_valid_i) begin
          next_f_tag    = req_tag;
          next_f_set    = req_set;
          next_f_word   = req_word;
          next_f_cnt    = 2'h0;
          next_f_issued = 1'b0;
          if (!enable) begin
            next_state = ST_DIRECT;
          end else if (any_hit) begin
            next_ack     = 1'b1;
            next_rdata   = w_data[hit_way];
            next_lru[req_set] = !hit_way;
          end else begin
            // victim is the way the set's bit points at
            next_state   = ST_FILL;
            next_f_way   = lru[req_set];
            next_f_store = !freeze;
          end
        end
      end
      ST_FILL: begin
        if (mem_valid_o && mem_ready_i)
          next_f_issued = 1'b1;
        if (mem_rvalid_i) begin
          next_f_cnt = f_cnt + 2'h1;
          if (f_cnt == f_word) begin
            next_ack   = 1'b1;
            next_rdata = mem_rdata_i;
          end
          if (f_cnt == 2'h3) begin
            next_state = ST_IDLE;
            if (f_store)
              next_lru[f_set] = !f_way;
          end
        end
      end
      ST_DIRECT: begin
        if (mem_valid_o && mem_ready_i)
          next_f_issued = 1'b1;
        if (mem_rvalid_i) begin
          next_ack   = 1'b1;
          next_rdata = mem_rdata_i;
          next_state = ST_IDLE;
        end
      end
      ST_FLUSH: begin
        // one set per cycle: 512 cycles to sweep the whole cache
        next_fl_idx = fl_idx + set_t'(1);
        if (flush_done)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      f_tag    <= '0;
      f_set    <= '0;
      f_word   <= '0;
      f_cnt    <= '0;
      f_way    <= 1'b0;
      f_store  <= 1'b0;
      f_issued <= 1'b0;
      ack      <= 1'b0;
      rdata    <= '0;
      fl_idx   <= '0;
      lru      <= '0;
    end else begin
      state    <= next_state;
      f_tag    <= next_f_tag;
      f_set    <= next_f_set;
      f_word   <= next_f_word;
      f_cnt    <= next_f_cnt;
      f_way    <= next_f_way;
      f_store  <= next_f_store;
      f_issued <= next_f_issued;
      ack      <= next_ack;
      rdata    <= next_rdata;
      fl_idx   <= next_fl_idx;
      lru      <= next_lru;
    end
  end

  hit_no_mem_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_IDLE && fetch_ready_o && fetch_valid_i && enable && any_hit
    |=> !mem_valid_o && fetch_ack_o && state == ST_IDLE)
    else $error("hit went to external memory");
  frozen_no_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_FILL && !f_store |-> w_wr_data == 2'b00 && w_wr_tag == 2'b00)
    else $error("frozen fill touched the arrays");
  frozen_fetch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_IDLE && fetch_ready_o && fetch_valid_i && enable && !any_hit && freeze
    |=> state == ST_FILL && !f_store && mem_valid_o && mem_req_o.line)
    else $error("frozen miss not fetched without storing");
  disabled_direct_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_IDLE && fetch_ready_o && fetch_valid_i && !enable
    |=> state == ST_DIRECT && mem_valid_o && !mem_req_o.line)
    else $error("disabled fetch not passed through");
  tag_last_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (|w_wr_tag) |-> last_word)
    else $error("tag written before line complete");
  fill_line_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mem_valid_o && mem_req_o.line |-> mem_req_o.addr[3:0] == 4'h0)
    else $error("fill not line aligned");
  stall_fill_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state != ST_IDLE |-> !fetch_ready_o)
    else $error("fetch accepted while busy");
  forward_word_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_FILL && mem_rvalid_i && f_cnt == f_word
    |=> fetch_ack_o && fetch_data_o == $past(mem_rdata_i))
    else $error("requested word not forwarded");
  flush_sweep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(inval) |-> inval [*8])
    else $error("flush sweep cut short");
  flush_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    flush_done |=> state == ST_IDLE)
    else $error("flush sweep did not end");
  flush_stall_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    flush |-> !fetch_ready_o)
    else $error("fetch accepted during flush");

  // checks on the replacement and memory side
  lru_hit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_IDLE && fetch_ready_o && fetch_valid_i && enable && any_hit
    |=> lru[$past(req_set)] == !$past(hit_way))
    else $error("hit did not mark the other way");
  fill_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    last_word |=> state == ST_IDLE)
    else $error("fill not closed after fourth word");
  direct_word_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == ST_DIRECT |-> !mem_req_o.line && mem_req_o.addr[1:0] == 2'h0)
    else $error("pass-through request malformed");
  mem_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_req_o))
    else $error("memory request dropped before accept");

endmodule : icache_top

// [testbench/fetch_mem_model.sv]
`timescale 1ns/1ps
// external memory stand-in: one request at a time, one or four words back
module fetch_mem_model
  import icache_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // request side
  input  wire logic              mem_valid_i,
  input  wire mem_req_s          mem_req_i,
  output logic                   mem_ready_o,
  // return side
  output logic                   mem_rvalid_o,
  output logic [DATA_W-1:0]      mem_rdata_o,
  // test controls
  input  wire logic              slow_i,
  input  wire logic [7:0]        gen_i,
  output logic                   busy_o
);
  mem_req_s          req;
  logic [ADDR_W-1:0] base;

  // word data carries the generation byte so stale lines can be told apart
  initial begin
    mem_ready_o  = 1'b0;
    mem_rvalid_o = 1'b0;
    mem_rdata_o  = 32'h0;
    busy_o       = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (mem_valid_i && !rst_i) begin
        if (slow_i) repeat (3) @(posedge mclk_i);
        mem_ready_o <= 1'b1;
        @(posedge mclk_i);
        req = mem_req_i;
        mem_ready_o <= 1'b0;
        busy_o      <= 1'b1;
        base = req.line ? {req.addr[23:4], 4'h0} : req.addr;
        // words of a line return in order 0..3
        // back-to-back words keep rvalid high; a slow memory leaves gaps
        for (int i = 0; i < (req.line ? 4 : 1); i++) begin
          if (slow_i) begin
            mem_rvalid_o <= 1'b0;
            mem_rdata_o  <= ~mem_rdata_o;
            repeat (2) @(posedge mclk_i);
          end
          mem_rvalid_o <= 1'b1;
          mem_rdata_o  <= {gen_i, base[23:2] + 22'(i), 2'h0};
          @(posedge mclk_i);
        end
        mem_rvalid_o <= 1'b0;
        mem_rdata_o  <= ~mem_rdata_o;  // released data must not linger
        busy_o       <= 1'b0;
      end
    end
  end
endmodule : fetch_mem_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
// self-checking bench for the two-way instruction cache
module testbench
  import icache_pkg::*;
;
  logic              mclk_i;
  logic              rst_i;
  logic [1:0]        reg_addr_i;
  logic [15:0]       reg_wdata_i;
  logic              reg_write_i;
  logic              reg_read_i;
  logic [15:0]       reg_rdata_o;
  logic              fetch_valid_i;
  fetch_req_s        fetch_req_i;
  logic              fetch_ready_o;
  logic              fetch_ack_o;
  logic [DATA_W-1:0] fetch_data_o;
  logic              mem_valid_o;
  mem_req_s          mem_req_o;
  logic              mem_ready_i;
  logic              mem_rvalid_i;
  logic [DATA_W-1:0] mem_rdata_i;
  logic              slow;
  logic [7:0]        gen;
  logic              busy;
  logic [7:0]        exp_gen;
  logic [ADDR_W-1:0] last_addr = '0;
  int                mismatches;
  int                total_checks;
  int                n_line = 0;
  int                n_word = 0;

  icache_top u_icache_top (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .fetch_valid_i(fetch_valid_i), .fetch_req_i(fetch_req_i),
    .fetch_ready_o(fetch_ready_o), .fetch_ack_o(fetch_ack_o), .fetch_data_o(fetch_data_o),
    .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o), .mem_ready_i(mem_ready_i),
    .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i));

  fetch_mem_model u_fetch_mem_model (.mclk_i(mclk_i), .rst_i(rst_i),
    .mem_valid_i(mem_valid_o), .mem_req_i(mem_req_o), .mem_ready_o(mem_ready_i),
    .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i), .slow_i(slow), .gen_i(gen),
    .busy_o(busy));

  // 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // count memory requests at the edge where the memory accepts them
  always @(posedge mclk_i) begin
    if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1) begin
      if (mem_req_o.line) n_line++;
      else n_word++;
      last_addr = mem_req_o.addr;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // a gap cycle after each strobe keeps every signal to one assignment a step
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge mclk_i);
    reg_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge mclk_i);
    reg_read_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;  // read data stand only in the cycle after the strobe
    @(posedge mclk_i);
  endtask : reg_rd

  // kind 0 hit, 1 line fill, 2 direct single word
  task automatic fetch(input logic [23:0] a, input int kind);
    int ln;
    int wn;
    int lat;
    ln = n_line;
    wn = n_word;
    lat = 0;
    fetch_req_i.addr <= a;
    fetch_valid_i    <= 1'b1;
    @(posedge mclk_i);
    while (fetch_ready_o !== 1'b1 && lat < 2000) begin
      @(posedge mclk_i);
      lat++;
    end
    fetch_valid_i <= 1'b0;
    lat = 0;
    while (fetch_ack_o !== 1'b1 && lat < 60) begin
      @(posedge mclk_i);
      lat++;
    end
    check("fetch ack", fetch_ack_o, 1'b1);
    check("fetch data", fetch_data_o, {exp_gen, a[23:2], 2'h0});
    check("line requests", n_line, ln + (kind == 1));
    check("word requests", n_word, wn + (kind == 2));
    if (kind == 0) check("hit latency", lat, 1);
    if (kind == 1) check("fill address", last_addr[23:4], a[23:4]);
    if (kind == 2) check("direct address", last_addr[23:2], a[23:2]);
  endtask : fetch

  // address in the shared set 034 with the given tag and word
  function automatic logic [23:0] la(input int t, input logic [1:0] w);
    return {11'(t), 9'h034, w, 2'h1};
  endfunction : la

  task automatic t_reset();
    logic [15:0] d;
    reg_rd(STATUS_OFS, d);
    check("status at reset", d, 16'h0000);
    reg_rd(GLOBAL_OFS, d);
    check("global at reset", d, GLOBAL_RST);
    reg_wr(2'h2, 16'hffff);
    reg_rd(2'h2, d);
    check("unmapped read", d, 16'h0000);
  endtask : t_reset

  task automatic t_disabled_and_enable();
    logic [15:0] d;
    fetch(24'h00a104, 2);
    fetch(24'h00a10b, 2);
    reg_wr(GLOBAL_OFS, GLOBAL_INIT);
    reg_rd(GLOBAL_OFS, d);
    check("global readback", d, GLOBAL_INIT);
    reg_wr(STATUS_OFS, 16'h4000);
    reg_rd(STATUS_OFS, d);
    check("status enabled", d, 16'h4000);
  endtask : t_disabled_and_enable

  // miss, stalled follow-up, every word of the line as hits, early forwarding
  task automatic t_miss_hit();
    fetch(24'h3a5a58, 1);
    fetch(24'h3a5a5c, 0);
    for (int i = 0; i < 4; i++) fetch({20'h3a5a5, 2'(i), 2'h3}, 0);
    slow <= 1'b1;
    fetch(24'h3a6b40, 1);
    check("forwarded early", busy, 1'b1);
    slow <= 1'b0;
    fetch(24'h3a6b4c, 0);
  endtask : t_miss_hit

  // two ways in one set: the least recently used line is the victim
  task automatic t_lru();
    int tg[8] = '{1, 2, 1, 3, 1, 3, 2, 1};
    int kd[8] = '{1, 1, 0, 1, 0, 0, 1, 1};
    for (int i = 0; i < 8; i++) fetch(la(tg[i], 2'(i)), kd[i]);
  endtask : t_lru

  task automatic t_freeze();
    logic [15:0] d;
    reg_wr(STATUS_OFS, 16'hc000);
    reg_rd(STATUS_OFS, d);
    check("status frozen", d, 16'hc000);
    fetch(24'h0a0770, 1);
    fetch(24'h0a0774, 1);
    fetch(la(1, 2'h2), 0);
    fetch(la(2, 2'h3), 0);
    reg_wr(STATUS_OFS, 16'h4000);
    fetch(24'h0a0770, 1);
    fetch(24'h0a0778, 0);
  endtask : t_freeze

  // memory changes under the cache; only a flush brings the new words in
  task automatic t_stale_flush();
    logic [15:0] d;
    int          n;
    gen <= 8'h5a;  // memory changes under a valid line; the cache keeps the old word
    @(posedge mclk_i);
    fetch(la(1, 2'h1), 0);
    reg_wr(STATUS_OFS, 16'h6000);
    reg_rd(STATUS_OFS, d);
    check("flush running", d[FLUSH_BIT], 1'b1);
    n = 0;
    while (d[FLUSH_BIT] !== 1'b0 && n < 400) begin
      reg_rd(STATUS_OFS, d);
      n++;
    end
    check("flush done", d, 16'h4000);
    exp_gen = 8'h5a;
    fetch(la(1, 2'h1), 1);
    fetch(24'h0a0774, 1);
  endtask : t_stale_flush

  // reset in mid-run drops enable and freeze, so fetches pass straight through
  task automatic t_mid_reset();
    logic [15:0] d;
    reg_wr(STATUS_OFS, 16'hc000);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    reg_rd(STATUS_OFS, d);
    check("status after reset", d, 16'h0000);
    fetch(24'h0a0778, 2);
  endtask : t_mid_reset

  // watchdog well beyond the expected several hundred cycles
  initial begin
    #1000000;
    mismatches++;
    results();
  end

  initial begin
    rst_i         = 1'b1;
    reg_addr_i    = 2'h0;
    reg_wdata_i   = 16'h0;
    reg_write_i   = 1'b0;
    reg_read_i    = 1'b0;
    fetch_valid_i = 1'b0;
    fetch_req_i   = '0;
    slow          = 1'b0;
    gen           = 8'hc3;
    exp_gen       = 8'hc3;
    mismatches    = 0;
    total_checks  = 0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    check("ready at reset", fetch_ready_o, 1'b1);
    t_reset();
    t_disabled_and_enable();
    t_miss_hit();
    t_lru();
    t_freeze();
    t_stale_flush();
    t_mid_reset();
    results();
  end
endmodule : testbench
